// ---- servo_cfg_pkg.sv ----
package servo_cfg_pkg;

    // Control mode codes.
    localparam logic [2:0] MODE_POSITION = 3'h0;
    localparam logic [2:0] MODE_SPEED = 3'h1;
    localparam logic [2:0] MODE_TORQUE = 3'h2;
    localparam logic [2:0] MODE_UPPER = 3'h5;

    // Register indices (word offsets; byte address is four times the index).
    localparam logic [3:0] REG_MODE = 4'h0;
    localparam logic [3:0] REG_IN_ASSIGN = 4'h1;
    localparam logic [3:0] REG_OUT_ASSIGN = 4'h2;
    localparam logic [3:0] REG_SPD_STEP = 4'h3;
    localparam logic [3:0] REG_TRQ_STEP = 4'h4;
    localparam logic [3:0] REG_SW_RANGE = 4'h5;
    localparam logic [3:0] REG_ACC_FF = 4'h6;
    localparam logic [3:0] REG_TRQ_FILT = 4'h7;
    localparam logic [3:0] REG_ACTIVE = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'h9;

    // Field widths and limits.
    localparam int SET_W = 14;
    localparam int CMD_W = 16;
    localparam logic [13:0] SET_MAX = 14'h270f;
    localparam logic [4:0] ASSIGN_MAX = 5'h14;

    // Reset values.
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [4:0] ASSIGN_RST = 5'h00;
    localparam logic [13:0] SW_RANGE_RST = 14'h0fa0;
    localparam logic [13:0] FACTOR_RST = 14'h0000;

    // Decoded drive functions fed by the input terminals.
    typedef struct packed {
        logic servo_on;
        logic fwd_inhibit;
        logic rev_inhibit;
        logic fwd_enable;
        logic rev_enable;
        logic clear;
        logic alarm_clear;
        logic dev_clear;
        logic speed_limit;
        logic current_limit;
        logic cmd_select;
    } in_func_s;

    // Drive status sources for the output terminals.
    typedef struct packed {
        logic inpos_ready;
        logic alarm;
        logic ready;
        logic limiting_speed;
        logic limiting_current;
        logic phase_z;
    } out_src_s;

endpackage

// ---- servo_mode_io_function_map.sv ----
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module servo_mode_io_function_map (
    // Clock and power-on reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Discrete input terminals 1 to 5 (bit 0 is input 1), asynchronous.
    input wire logic [4:0] io_in,
    // Decoded drive functions.
    output servo_cfg_pkg::in_func_s func_ff,
    // Drive status sources and output terminals 1 to 5.
    input wire servo_cfg_pkg::out_src_s out_src,
    output logic [4:0] io_out_ff,
    // Command paths and step correction.
    input wire logic pulse_cmd_valid,
    input wire logic signed [15:0] pulse_speed_cmd,
    input wire logic signed [15:0] analog_speed_cmd,
    input wire logic signed [15:0] torque_cmd,
    input wire logic signed [31:0] deviation,
    output logic signed [15:0] speed_cmd_ff,
    output logic signed [15:0] torque_cmd_ff,
    output logic analog_sel_ff,
    // Factors held for the loop arithmetic.
    output logic [13:0] acc_ff_factor_ff,
    output logic [13:0] trq_filt_factor_ff
);
    import servo_cfg_pkg::*;

    // Stored settings model the nonvolatile parameter memory: a power cycle on
    // rst_n must not wipe them, or a new mode could never reach the latch below.
    logic [2:0] mode_set_ff = MODE_RST;
    logic [4:0] in_asg_set_ff = ASSIGN_RST;
    logic [4:0] out_asg_set_ff = ASSIGN_RST;
    logic [13:0] spd_step_ff = FACTOR_RST;
    logic [13:0] trq_step_ff = FACTOR_RST;
    logic [13:0] sw_range_ff = SW_RANGE_RST;
    logic [13:0] acc_set_ff = FACTOR_RST;
    logic [13:0] flt_set_ff = FACTOR_RST;
    // Latched copies used by the logic; loaded once after power-up.
    logic [2:0] mode_act_ff;
    logic [4:0] in_asg_act_ff;
    logic [4:0] out_asg_act_ff;
    logic latched_ff;
    logic [4:0] in_meta_ff;
    logic [4:0] in_sync_ff;

    // Write decode; settings saturate at the documented limits.
    wire wr_mode = reg_wr && (reg_addr == REG_MODE);
    wire wr_in = reg_wr && (reg_addr == REG_IN_ASSIGN);
    wire wr_out = reg_wr && (reg_addr == REG_OUT_ASSIGN);
    wire wr_spd = reg_wr && (reg_addr == REG_SPD_STEP);
    wire wr_trq = reg_wr && (reg_addr == REG_TRQ_STEP);
    wire wr_rng = reg_wr && (reg_addr == REG_SW_RANGE);
    wire wr_acc = reg_wr && (reg_addr == REG_ACC_FF);
    wire wr_flt = reg_wr && (reg_addr == REG_TRQ_FILT);
    wire over_set = reg_wdata[31:14] != 18'h00000 || reg_wdata[13:0] > SET_MAX;
    wire [13:0] nxt_set = over_set ? SET_MAX : reg_wdata[13:0];
    wire [2:0] nxt_mode = (reg_wdata[31:3] != 29'h0) ? MODE_UPPER :
        (reg_wdata[2:0] > MODE_UPPER ? MODE_UPPER : reg_wdata[2:0]);
    wire [4:0] nxt_asg = (reg_wdata[31:5] != 27'h0 || reg_wdata[4:0] > ASSIGN_MAX) ?
        ASSIGN_MAX : reg_wdata[4:0];

    // Setting registers; reserved mode codes are stored but are the writer's problem.
    // There is no reset here on purpose, so the values outlive a power cycle.
    always_ff @(posedge clk) begin
        if (wr_mode) mode_set_ff <= nxt_mode;
        if (wr_in) in_asg_set_ff <= nxt_asg;
        if (wr_out) out_asg_set_ff <= nxt_asg;
        if (wr_spd) spd_step_ff <= nxt_set;
        if (wr_trq) trq_step_ff <= nxt_set;
        if (wr_rng) sw_range_ff <= nxt_set;
        if (wr_acc) acc_set_ff <= nxt_set;
        if (wr_flt) flt_set_ff <= nxt_set;
    end

    // Active copies load once, on the first edge after reset release. Software
    // must have nonvolatile values loaded by then; later writes wait a power cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latched_ff <= 1'b0;
            mode_act_ff <= MODE_RST;
            in_asg_act_ff <= ASSIGN_RST;
            out_asg_act_ff <= ASSIGN_RST;
        end else if (!latched_ff) begin
            latched_ff <= 1'b1;
            mode_act_ff <= mode_set_ff;
            in_asg_act_ff <= in_asg_set_ff;
            out_asg_act_ff <= out_asg_set_ff;
        end
    end

    // Two-stage synchroniser for the terminal inputs.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_meta_ff <= 5'h00;
            in_sync_ff <= 5'h00;
        end else begin
            in_meta_ff <= io_in;
            in_sync_ff <= in_meta_ff;
        end
    end

    // Mode decode; reserved codes fall back to position behaviour.
    wire is_speed = mode_act_ff == MODE_SPEED;
    wire is_torque = mode_act_ff == MODE_TORQUE;
    wire is_pos = !is_speed && !is_torque;

    // Input function map.
    in_func_s nxt_func;
    always_comb begin
        nxt_func = '0;
        nxt_func.servo_on = in_sync_ff[0];
        if (is_pos) begin
            unique case (in_asg_act_ff)
                5'h00: begin
                    nxt_func.fwd_inhibit = in_sync_ff[1];
                    nxt_func.rev_inhibit = in_sync_ff[2];
                    nxt_func.alarm_clear = in_sync_ff[3];
                    nxt_func.dev_clear = in_sync_ff[4];
                end
                5'h01: begin
                    nxt_func.fwd_inhibit = in_sync_ff[1];
                    nxt_func.rev_inhibit = in_sync_ff[2];
                    nxt_func.clear = in_sync_ff[3];
                    nxt_func.speed_limit = in_sync_ff[4];
                end
                5'h02: begin
                    nxt_func.fwd_inhibit = in_sync_ff[1];
                    nxt_func.rev_inhibit = in_sync_ff[2];
                    nxt_func.clear = in_sync_ff[3];
                    nxt_func.current_limit = in_sync_ff[4];
                end
                5'h03: begin
                    nxt_func.alarm_clear = in_sync_ff[1];
                    nxt_func.dev_clear = in_sync_ff[2];
                    nxt_func.speed_limit = in_sync_ff[3];
                    nxt_func.current_limit = in_sync_ff[4];
                end
                default: nxt_func.servo_on = in_sync_ff[0]; // Reserved codes map nothing else.
            endcase
        end else begin
            nxt_func.fwd_enable = in_sync_ff[1];
            nxt_func.rev_enable = in_sync_ff[2];
            if (is_speed) begin
                unique case (in_asg_act_ff)
                    5'h00: begin
                        nxt_func.clear = in_sync_ff[3];
                        nxt_func.speed_limit = in_sync_ff[4];
                    end
                    5'h01: begin
                        nxt_func.clear = in_sync_ff[3];
                        nxt_func.current_limit = in_sync_ff[4];
                    end
                    5'h02: begin
                        nxt_func.speed_limit = in_sync_ff[3];
                        nxt_func.current_limit = in_sync_ff[4];
                    end
                    5'h03: begin
                        nxt_func.clear = in_sync_ff[3];
                        nxt_func.cmd_select = in_sync_ff[4];
                    end
                    5'h04: begin
                        nxt_func.cmd_select = in_sync_ff[3];
                        nxt_func.speed_limit = in_sync_ff[4];
                    end
                    5'h05: begin
                        nxt_func.cmd_select = in_sync_ff[3];
                        nxt_func.current_limit = in_sync_ff[4];
                    end
                    default: nxt_func.clear = 1'b0;
                endcase
            end else begin
                unique case (in_asg_act_ff)
                    5'h00: begin
                        nxt_func.clear = in_sync_ff[3];
                        nxt_func.current_limit = in_sync_ff[4];
                    end
                    5'h01: begin
                        nxt_func.clear = in_sync_ff[3];
                        nxt_func.cmd_select = in_sync_ff[4];
                    end
                    5'h02: begin
                        nxt_func.cmd_select = in_sync_ff[3];
                        nxt_func.current_limit = in_sync_ff[4];
                    end
                    default: nxt_func.clear = 1'b0;
                endcase
            end
        end
    end

    // Output map; the same three tables serve every mode, other assignment codes use setting 0.
    logic [4:0] nxt_out;
    always_comb begin
        nxt_out = {out_src.phase_z, 2'b00, out_src.alarm, out_src.inpos_ready};
        unique case (out_asg_act_ff)
            5'h01: nxt_out[3:2] = {out_src.limiting_current, out_src.ready};
            5'h02: nxt_out[3:2] = {out_src.limiting_current, out_src.limiting_speed};
            default: nxt_out[3:2] = {out_src.limiting_speed, out_src.ready};
        endcase
    end

    // Step correction gate and signed corrections.
    wire [31:0] dev_mag = deviation[31] ? 32'(-deviation) : 32'(deviation);
    wire step_on = is_pos && (dev_mag > {18'h00000, sw_range_ff});
    wire signed [15:0] base_speed = is_pos ? pulse_speed_cmd : analog_speed_cmd;
    wire signed [15:0] spd_amt = {2'b00, spd_step_ff};
    wire signed [15:0] trq_amt = {2'b00, trq_step_ff};
    wire signed [15:0] spd_corr = base_speed[15] ? -spd_amt : spd_amt;
    wire signed [15:0] trq_corr = torque_cmd[15] ? -trq_amt : trq_amt;
    wire signed [15:0] nxt_speed = step_on ? 16'(base_speed + spd_corr) : base_speed;
    wire signed [15:0] nxt_torque = step_on ? 16'(torque_cmd + trq_corr) : torque_cmd;

    // Output registers; pulse path only advances when a pulse command is valid.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            func_ff <= '0;
            io_out_ff <= 5'h00;
            speed_cmd_ff <= 16'sh0000;
            torque_cmd_ff <= 16'sh0000;
            analog_sel_ff <= 1'b0;
            acc_ff_factor_ff <= FACTOR_RST;
            trq_filt_factor_ff <= FACTOR_RST;
        end else begin
            acc_ff_factor_ff <= acc_set_ff;
            trq_filt_factor_ff <= flt_set_ff;
            func_ff <= nxt_func;
            io_out_ff <= nxt_out;
            analog_sel_ff <= !is_pos;
            if (!is_pos || pulse_cmd_valid) speed_cmd_ff <= nxt_speed;
            torque_cmd_ff <= nxt_torque;
        end
    end

    // Read mux; unmapped addresses read zero.
    logic [31:0] nxt_rdata;
    always_comb begin
        unique case (reg_addr)
            REG_MODE: nxt_rdata = {29'h0, mode_set_ff};
            REG_IN_ASSIGN: nxt_rdata = {27'h0, in_asg_set_ff};
            REG_OUT_ASSIGN: nxt_rdata = {27'h0, out_asg_set_ff};
            REG_SPD_STEP: nxt_rdata = {18'h0, spd_step_ff};
            REG_TRQ_STEP: nxt_rdata = {18'h0, trq_step_ff};
            REG_SW_RANGE: nxt_rdata = {18'h0, sw_range_ff};
            REG_ACC_FF: nxt_rdata = {18'h0, acc_set_ff};
            REG_TRQ_FILT: nxt_rdata = {18'h0, flt_set_ff};
            REG_ACTIVE: nxt_rdata = {19'h0, out_asg_act_ff, in_asg_act_ff, mode_act_ff};
            REG_STATUS: nxt_rdata = {30'h0, step_on, latched_ff};
            default: nxt_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? nxt_rdata : 32'h0;
        end
    end

    // Active settings never move once latched.
    a_mode_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        $past(latched_ff) |-> $stable(mode_act_ff))
        else $error("active mode changed after power-up");
    a_assign_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        $past(latched_ff) |-> $stable(in_asg_act_ff) && $stable(out_asg_act_ff))
        else $error("active assignment changed after power-up");
    a_analog_select: assert property (@(posedge clk) disable iff (!rst_n)
        latched_ff ##1 latched_ff |-> analog_sel_ff == $past(!is_pos))
        else $error("command source does not follow mode");
    a_step_gate: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && !step_on |=> torque_cmd_ff == $past(torque_cmd))
        else $error("torque correction applied outside switch range");
    a_trq_sign: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && step_on && !torque_cmd[15] && torque_cmd < 16'sh4000 && trq_step_ff != 14'h0
        |=> torque_cmd_ff > $past(torque_cmd))
        else $error("torque correction sign wrong");
    a_spd_sign: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && step_on && pulse_cmd_valid && base_speed[15] && base_speed > -16'sh4000
        && spd_step_ff != 14'h0 |=> speed_cmd_ff < $past(base_speed))
        else $error("speed correction sign wrong");
    a_servo_on_map: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n |-> ##3 func_ff.servo_on == $past(io_in[0], 3))
        else $error("servo-on not taken from input 1");
    a_unused_idle: assert property (@(posedge clk) disable iff (!rst_n)
        is_speed |=> !func_ff.fwd_inhibit && !func_ff.rev_inhibit
        && !func_ff.alarm_clear && !func_ff.dev_clear)
        else $error("unmapped function active");
    a_pos_enables_off: assert property (@(posedge clk) disable iff (!rst_n)
        is_pos |=> !func_ff.fwd_enable && !func_ff.rev_enable)
        else $error("enable active in position mode");
    a_out_fixed: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n |=> io_out_ff[0] == $past(out_src.inpos_ready)
        && io_out_ff[4] == $past(out_src.phase_z))
        else $error("fixed output terminal wrong");
    a_torque_map: assert property (@(posedge clk) disable iff (!rst_n)
        is_torque && in_asg_act_ff == 5'h02 |=> func_ff.cmd_select == $past(in_sync_ff[3]))
        else $error("torque assignment 2 input 4 wrong");
    a_speed_map: assert property (@(posedge clk) disable iff (!rst_n)
        is_speed && in_asg_act_ff == 5'h02 |=> func_ff.current_limit == $past(in_sync_ff[4]))
        else $error("speed assignment 2 input 5 wrong");

endmodule

// ---- host_model.sv ----
`timescale 1ns/1ns
module host_model (
    // Clock of the drive.
    input wire logic clk,
    // Values the bench wants the controller to present.
    input wire logic [4:0] want_io,
    input wire logic signed [15:0] want_p,
    input wire logic signed [15:0] want_a,
    input wire logic signed [15:0] want_t,
    input wire logic signed [31:0] want_dev,
    input wire logic want_v,
    // Terminals and command lines towards the drive.
    output logic [4:0] io_in,
    output logic pulse_cmd_valid,
    output logic signed [15:0] pulse_speed_cmd,
    output logic signed [15:0] analog_speed_cmd,
    output logic signed [15:0] torque_cmd,
    output logic signed [31:0] deviation
);
    // Lines start quiet so nothing is unknown before the first edge.
    initial begin
        io_in = 5'h00;
        pulse_cmd_valid = 1'b0;
        pulse_speed_cmd = 16'h0000;
        analog_speed_cmd = 16'h0000;
        torque_cmd = 16'h0000;
        deviation = 32'h00000000;
    end

    // The controller moves its lines only on the clock, like an output register.
    always @(posedge clk) begin
        io_in <= want_io;
        pulse_cmd_valid <= want_v;
        pulse_speed_cmd <= want_p;
        analog_speed_cmd <= want_a;
        torque_cmd <= want_t;
        deviation <= want_dev;
    end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    import servo_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [4:0] want_io = 5'h00;
    logic signed [15:0] want_p = 16'h0000;
    logic signed [15:0] want_a = 16'h0000;
    logic signed [15:0] want_t = 16'h0000;
    logic signed [31:0] want_dev = 32'h0;
    logic want_v = 1'b1;
    logic [4:0] io_in;
    logic pulse_cmd_valid;
    logic signed [15:0] pulse_speed_cmd;
    logic signed [15:0] analog_speed_cmd;
    logic signed [15:0] torque_cmd;
    logic signed [31:0] deviation;
    in_func_s func_ff;
    out_src_s out_src = out_src_s'(6'h00);
    logic [4:0] io_out_ff;
    logic signed [15:0] speed_cmd_ff;
    logic signed [15:0] torque_cmd_ff;
    logic analog_sel_ff;
    logic [13:0] acc_ff_factor_ff;
    logic [13:0] trq_filt_factor_ff;
    int fail_count = 0;
    int tests_run = 0;
    logic [31:0] act_exp = 32'h0;
    // Function bit index per input terminal, input 5 in the top nibble.
    logic [19:0] in_tbl [13] = '{20'h3489a, 20'h2589a, 20'h1589a, 20'h1234a, 20'h2567a,
        20'h1567a, 20'h1267a, 20'h0567a, 20'h2067a, 20'h1067a, 20'h1567a, 20'h0567a, 20'h1067a};
    // Status source bit per output terminal for output assignments 0 to 2.
    logic [19:0] out_tbl [3] = '{20'h02345, 20'h01345, 20'h01245};

    // A 100 ns clock.
    always #50 clk = ~clk;

    host_model host (.clk(clk), .want_io(want_io), .want_p(want_p), .want_a(want_a),
        .want_t(want_t), .want_dev(want_dev), .want_v(want_v), .io_in(io_in),
        .pulse_cmd_valid(pulse_cmd_valid), .pulse_speed_cmd(pulse_speed_cmd),
        .analog_speed_cmd(analog_speed_cmd), .torque_cmd(torque_cmd),
        .deviation(deviation));

    servo_mode_io_function_map dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .io_in(io_in), .func_ff(func_ff), .out_src(out_src), .io_out_ff(io_out_ff),
        .pulse_cmd_valid(pulse_cmd_valid), .pulse_speed_cmd(pulse_speed_cmd),
        .analog_speed_cmd(analog_speed_cmd), .torque_cmd(torque_cmd),
        .deviation(deviation), .speed_cmd_ff(speed_cmd_ff), .torque_cmd_ff(torque_cmd_ff),
        .analog_sel_ff(analog_sel_ff), .acc_ff_factor_ff(acc_ff_factor_ff),
        .trq_filt_factor_ff(trq_filt_factor_ff));

    // Compares one result; case inequality keeps unknowns from matching.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One write cycle; the idle cycle after it keeps strobes single.
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // One read cycle; data is taken mid-cycle after the read edge.
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
    endtask

    // Covers model register, two sync stages and the output register.
    task automatic settle;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask

    // Writes new settings, shows they wait, then cycles power.
    task automatic pwr(input logic [2:0] m, input logic [4:0] ia, input logic [4:0] oa);
        logic [31:0] v;
        wr(REG_MODE, {29'h0, m});
        wr(REG_IN_ASSIGN, {27'h0, ia});
        wr(REG_OUT_ASSIGN, {27'h0, oa});
        rd(REG_ACTIVE, v);
        chk(v, act_exp);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        act_exp = {19'h0, oa, ia, m};
        rd(REG_ACTIVE, v);
        chk(v, act_exp);
    endtask

    // Reset values, an unmapped read and saturation of a factor.
    task automatic test_reset;
        logic [31:0] v;
        rd(REG_SW_RANGE, v);
        chk(v, 32'h0fa0);
        rd(REG_ACC_FF, v);
        chk(v, 32'h0);
        rd(REG_TRQ_FILT, v);
        chk(v, 32'h0);
        rd(REG_MODE, v);
        chk(v, 32'h0);
        rd(4'hf, v);
        chk(v, 32'h0);
        chk({31'h0, analog_sel_ff}, 32'h0);
        wr(REG_ACC_FF, 32'h2710);
        rd(REG_ACC_FF, v);
        chk(v, 32'h270f);
        wr(REG_TRQ_FILT, 32'h04d2);
        rd(REG_TRQ_FILT, v);
        chk(v, 32'h04d2);
        $display("test_reset done");
    endtask

    // Step correction at and beyond the range, both signs and a zero command.
    task automatic test_step;
        logic [15:0] tq [4] = '{16'h0064, 16'h0064, 16'hff9c, 16'h0000};
        logic [15:0] sp [4] = '{16'h00c8, 16'h00c8, 16'hff38, 16'h0000};
        logic [31:0] dv [4] = '{32'h0000000a, 32'h0000000b, 32'hfffffff5, 32'h0000000b};
        logic [15:0] et [4] = '{16'h0064, 16'h006d, 16'hff93, 16'h0009};
        logic [15:0] es [4] = '{16'h00c8, 16'h00cf, 16'hff31, 16'h0007};
        wr(REG_SPD_STEP, 32'h7);
        wr(REG_TRQ_STEP, 32'h9);
        wr(REG_SW_RANGE, 32'ha);
        pwr(MODE_POSITION, 5'h00, 5'h00);
        chk({18'h0, acc_ff_factor_ff}, 32'h270f);
        chk({18'h0, trq_filt_factor_ff}, 32'h04d2);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            want_t <= tq[k];
            want_p <= sp[k];
            want_dev <= dv[k];
            settle();
            chk({16'h0, torque_cmd_ff}, {16'h0, et[k]});
            chk({16'h0, speed_cmd_ff}, {16'h0, es[k]});
        end
        // Without a valid pulse command the speed must hold while torque still follows.
        @(posedge clk);
        want_v <= 1'b0;
        want_p <= 16'h0100;
        want_t <= 16'h0020;
        settle();
        chk({16'h0, speed_cmd_ff}, 32'h0007);
        chk({16'h0, torque_cmd_ff}, 32'h0029);
        @(posedge clk);
        want_v <= 1'b1;
        $display("test_step done");
    endtask

    // One mode and assignment pair: terminal mapping, plus outputs for pairs 0 to 2 and the command path for pair 4.
    task automatic test_map(input int i);
        logic [2:0] m;
        logic [4:0] ia;
        logic [31:0] e;
        m = (i < 4) ? MODE_POSITION : (i < 10) ? MODE_SPEED : MODE_TORQUE;
        ia = (i < 4) ? i[4:0] : (i < 10) ? 5'(i - 4) : 5'(i - 10);
        pwr(m, ia, (i < 3) ? i[4:0] : 5'h00);
        chk({31'h0, analog_sel_ff}, {31'h0, m != MODE_POSITION});
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            want_io <= 5'(1 << k);
            settle();
            e = 32'h1 << in_tbl[i][4*k +: 4];
            chk({21'h0, func_ff}, e);
        end
        for (int j = 0; j < 6 && i < 3; j++) begin
            @(posedge clk);
            out_src <= out_src_s'(6'(1 << j));
            settle();
            e = 32'h0;
            for (int k = 0; k < 5; k++)
                e[k] = (out_tbl[i][4*k +: 4] == 4'(j));
            chk({27'h0, io_out_ff}, e);
        end
        if (i == 4) begin
            @(posedge clk);
            want_a <= 16'h012c;
            want_t <= 16'h0032;
            want_dev <= 32'h00010000;
            settle();
            chk({16'h0, speed_cmd_ff}, 32'h012c);
            chk({16'h0, torque_cmd_ff}, 32'h0032);
        end
        $display("test_map %0d done", i);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish;
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence after a four-cycle reset.
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_step();
        for (int i = 0; i < 13; i++)
            test_map(i);
        tally_and_finish();
    end

    // The run needs under 2000 cycles; ten times that means a hang.
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
endmodule
